// [bench/cpw_load.sv]
// Load model tallying the complementary pair
`timescale 1ns/1ps
module cpw_load (
  input wire logic sys_clk, // System clock
  input wire logic pol, // Active-low select
  input wire logic a, // Primary output
  input wire logic b, // Complementary output
  input wire logic clr, // Restart tallies
  output int overlap, // Cycles both active
  output int gap_min, // Shortest both-off run before a rise
  output int a_on, // Cycles primary active
  output int b_on // Cycles complementary active
);
  logic act_a;
  logic act_b;
  logic pa = 1'h0;
  logic pb = 1'h0;
  int gap = 0;
  assign act_a = a ^ pol;
  assign act_b = b ^ pol;
  always @(posedge sys_clk) begin
    pa <= act_a;
    pb <= act_b;
    if (clr) begin
      overlap <= 0;
      a_on <= 0;
      b_on <= 0;
      gap_min <= 1000;
      gap <= 0;
    end else begin
      overlap <= overlap + (act_a & act_b);
      a_on <= a_on + act_a;
      b_on <= b_on + act_b;
      gap <= (act_a | act_b) ? 0 : gap + 1;
      if (((act_a & !pa) | (act_b & !pb)) && gap < gap_min) gap_min <= gap;
    end
  end
endmodule

// [bench/cpw_top_bench.sv]
// Self-checking bench for the complementary modulator
`timescale 1ns/1ps
module cpw_top_bench import cpw_pkg::*; ;
  logic sys_clk = 1'h0;
  logic reset = 1'h1;
  logic wr_en = 1'h0;
  logic ena = 1'h0;
  logic pol = 1'h0;
  logic ea = 1'h0;
  logic eb = 1'h0;
  logic ie = 1'h0;
  logic ic = 1'h0;
  logic clr = 1'h1;
  logic [2:0] wr_sel = 3'h0;
  logic [7:0] wr_data = 8'h00;
  logic out_a, out_b, ovf, irq, unl;
  logic [11:0] per_v, dut_v;
  logic [7:0] dt_v;
  int overlap, gap_min, a_on, b_on, p, d;
  int n_fail = 0, n_checks = 0, cyc = 0;
  int m_unl = 0, m_per = 'hfff, m_dut = 0, m_dt = 0, lo_p = 0, lo_d = 0;
  always #10 sys_clk = ~sys_clk;
  cpw_top i_dut (.sys_clk(sys_clk), .reset(reset), .wr_en(wr_en), .wr_sel(wr_sel),
    .wr_data(wr_data), .modulator_block_enable(ena), .output_polarity_select(pol),
    .out_a_enable(ea), .out_b_enable(eb), .irq_enable(ie), .irq_clear(ic),
    .pwm_out_a(out_a), .pwm_out_b(out_b), .ovf_flag(ovf), .irq(irq), .unlocked(unl),
    .period_value(per_v), .duty_value(dut_v), .dead_time(dt_v));
  cpw_load i_load (.sys_clk(sys_clk), .pol(pol), .a(out_a), .b(out_b), .clr(clr),
    .overlap(overlap), .gap_min(gap_min), .a_on(a_on), .b_on(b_on));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic chk_b(input string nm, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Byte write plus the reference register model
  task automatic wr(input logic [2:0] s, input logic [7:0] v);
    wr_sel = s;
    wr_data = v;
    wr_en = 1'h1;
    run(1);
    wr_en = 1'h0;
    if (s == CPW_SEL_UNLOCK) m_unl = (v == CPW_UNLOCK_KEY);
    else if (m_unl != 0) case (s)
      CPW_SEL_PER_LO: lo_p = v;
      CPW_SEL_PER_HI: m_per = {v[3:0], lo_p[7:0]};
      CPW_SEL_DUT_LO: lo_d = v;
      CPW_SEL_DUT_HI: m_dut = {v[3:0], lo_d[7:0]};
      CPW_SEL_DEAD: if (!ena) m_dt = v;
      default: ;
    endcase
    run(1);
  endtask
  task automatic chk_regs();
    chk("period", 12'(m_per), per_v);
    chk("duty", 12'(m_dut), dut_v);
    chk("dead", 12'(m_dt), {4'h0, dt_v});
    chk_b("unlocked", m_unl[0], unl);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(1439));
    run(4);
    reset = 1'h0;
    chk_regs();
    wr(CPW_SEL_PER_LO, 8'h20);
    wr(CPW_SEL_PER_HI, 8'h00);
    chk_regs();
    $display("test locked done");
    wr(CPW_SEL_UNLOCK, CPW_UNLOCK_KEY);
    p = 32 + $urandom % 64;
    d = 8 + $urandom % (p - 16);
    wr(CPW_SEL_PER_LO, p[7:0]);
    chk_regs();
    wr(CPW_SEL_PER_HI, 8'hf0);
    wr(CPW_SEL_DUT_LO, d[7:0]);
    chk_regs();
    wr(CPW_SEL_DUT_HI, 8'h00);
    chk_regs();
    $display("test byte pairs done");
    for (int k = 0; k < 2; k++) begin
      pol = k[0];
      ena = 1'h0;
      ea = 1'h1;
      eb = 1'h1;
      clr = 1'h1;
      wr(CPW_SEL_DEAD, 8'h00);
      wr(CPW_SEL_DEAD, 8'($urandom % 6 + 1));
      chk_regs();
      chk_b("idle_a", pol, out_a);
      chk_b("idle_b", pol, out_b);
      ena = 1'h1;
      clr = 1'h0;
      wr(CPW_SEL_DEAD, 8'h33);
      chk_regs();
      run(3 * p);
      chk_b("overlap", 1'h1, overlap == 0);
      chk_b("gap", 1'h1, gap_min >= m_dt);
      chk_b("a_on", 1'h1, a_on > 0);
      chk_b("b_on", 1'h1, b_on > 0);
      $display("test pair polarity %0d done", k);
    end
    // A alone, then B alone; two cycles with clr held drain the output register
    for (int k = 0; k < 2; k++) begin
      ea = !k[0];
      eb = k[0];
      clr = 1'h1;
      run(2);
      clr = 1'h0;
      run(3 * p);
      chk_b("single_a", !k[0], a_on > 0);
      chk_b("single_b", k[0], b_on > 0);
    end
    $display("test single enable done");
    ie = 1'h1;
    ic = 1'h1;
    run(1);
    ic = 1'h0;
    for (int i = 0; i < p + 4 && ovf !== 1'h1; i++) run(1);
    chk_b("ovf", 1'h1, ovf);
    chk_b("irq", 1'h1, irq);
    ie = 1'h0;
    run(1);
    chk_b("irq_off", 1'h0, irq);
    chk_b("ovf_hold", 1'h1, ovf);
    ic = 1'h1;
    run(1);
    ic = 1'h0;
    chk_b("ovf_clr", 1'h0, ovf);
    $display("test overflow done");
    wr(CPW_SEL_UNLOCK, 8'h00);
    wr(CPW_SEL_DUT_LO, 8'h01);
    wr(CPW_SEL_DUT_HI, 8'h00);
    chk_regs();
    $display("test relock done");
    report_and_stop();
  end
endmodule

// [verilog/cpw_dead_time.sv]
// Dead-time delay of one output's rising edge
`timescale 1ns/1ps
module cpw_dead_time import cpw_pkg::*; #(
  parameter int DT_W = CPW_DT_W
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Async reset, high
  input wire logic req, // Raw request for this output
  input wire logic other_on, // Other output currently active
  input wire logic [DT_W-1:0] dead, // Dead-time cycles
  output logic on // Delayed active level
);
  cpw_dt_state_t state_r, state_nxt;
  logic [DT_W-1:0] cnt_r, cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    case (state_r)
      CPW_OFF: begin
        cnt_nxt = '0;
        if (req && !other_on) begin
          if (dead == '0) begin
            state_nxt = CPW_ON;
          end else begin
            state_nxt = CPW_WAIT;
            cnt_nxt = DT_W'(1);
          end
        end
      end
      CPW_WAIT: begin
        if (!req || other_on) begin
          state_nxt = CPW_OFF;
        end else if (cnt_r >= dead) begin
          state_nxt = CPW_ON;
        end else begin
          cnt_nxt = cnt_r + DT_W'(1);
        end
      end
      CPW_ON: begin
        if (!req) begin
          state_nxt = CPW_OFF;
        end
      end
      default: state_nxt = CPW_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= CPW_OFF;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign on = (state_r == CPW_ON);
endmodule

// [verilog/cpw_pkg.sv]
// Constants for the complementary modulator with dead time
package cpw_pkg;
  localparam int CPW_VAL_W = 12;
  localparam int CPW_DT_W = 8;
  localparam logic [7:0] CPW_UNLOCK_KEY = 8'h55;
  localparam logic [11:0] CPW_PERIOD_RST = 12'hfff;
  localparam logic [11:0] CPW_DUTY_RST = 12'h000;
  localparam logic [7:0] CPW_DT_RST = 8'h00;
  // Byte select encodings on the write port
  localparam logic [2:0] CPW_SEL_PER_LO = 3'h0;
  localparam logic [2:0] CPW_SEL_PER_HI = 3'h1;
  localparam logic [2:0] CPW_SEL_DUT_LO = 3'h2;
  localparam logic [2:0] CPW_SEL_DUT_HI = 3'h3;
  localparam logic [2:0] CPW_SEL_DEAD = 3'h4;
  localparam logic [2:0] CPW_SEL_UNLOCK = 3'h5;
  typedef enum logic [2:0] {
    CPW_OFF = 3'b001,
    CPW_WAIT = 3'b010,
    CPW_ON = 3'b100
  } cpw_dt_state_t;
endpackage

// [verilog/cpw_top.sv]
// Complementary modulator with dead time, unlock and overflow flag
`timescale 1ns/1ps
//
// Contract
// - Two complementary outputs from one period/duty
// - Polarity bit selects active high or low
// - Each output has its own enable
// - Both enabled gives complementary pair with dead time
// - Interrupt on every period counter overflow
// - 12-bit values, low then high byte
// - Low byte alone leaves value unchanged
// - Dead time writable only while block disabled
// - Writes need unlock key 0x55 first
module cpw_top import cpw_pkg::*; #(
  parameter int VAL_W = CPW_VAL_W,
  parameter int DT_W = CPW_DT_W
) (
  input wire logic sys_clk, // System clock 50 MHz
  input wire logic reset, // Async reset, high
  input wire logic wr_en, // One-cycle byte write strobe
  input wire logic [2:0] wr_sel, // Target byte select
  input wire logic [7:0] wr_data, // Write byte
  input wire logic modulator_block_enable, // Run counter and outputs
  input wire logic output_polarity_select, // 1 = active low outputs
  input wire logic out_a_enable, // Enable primary output
  input wire logic out_b_enable, // Enable complementary output
  input wire logic irq_enable, // Overflow interrupt enable
  input wire logic irq_clear, // Clear overflow flag pulse
  output logic pwm_out_a, // Primary output
  output logic pwm_out_b, // Complementary output
  output logic ovf_flag, // Sticky overflow flag
  output logic irq, // Interrupt request
  output logic unlocked, // Unlock key held
  output logic [VAL_W-1:0] period_value, // Active period
  output logic [VAL_W-1:0] duty_value, // Active duty
  output logic [DT_W-1:0] dead_time // Active dead time
);
  logic [VAL_W-1:0] period_r, period_nxt, duty_r, duty_nxt;
  logic [7:0] per_lo_r, per_lo_nxt, dut_lo_r, dut_lo_nxt;
  logic [DT_W-1:0] dead_r, dead_nxt;
  logic unlock_r, unlock_nxt;
  logic [VAL_W-1:0] cnt_r, cnt_nxt;
  logic ovf_r, ovf_nxt;
  logic a_r, a_nxt, b_r, b_nxt;
  logic wr_ok, wrap, raw_high, req_a, req_b, on_a, on_b, both;

  function automatic logic [VAL_W-1:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
    logic [15:0] w;
    w = {hi, lo};
    return w[VAL_W-1:0];
  endfunction

  ////////////////////////////////////////////////////////////////
  // Register writes
  assign wr_ok = wr_en && unlock_r;

  always_comb begin
    period_nxt = period_r;
    duty_nxt = duty_r;
    per_lo_nxt = per_lo_r;
    dut_lo_nxt = dut_lo_r;
    dead_nxt = dead_r;
    unlock_nxt = unlock_r;
    if (wr_en && wr_sel == CPW_SEL_UNLOCK) begin
      unlock_nxt = (wr_data == CPW_UNLOCK_KEY);
    end
    if (wr_ok) begin
      case (wr_sel)
        CPW_SEL_PER_LO: per_lo_nxt = wr_data;
        CPW_SEL_PER_HI: period_nxt = join_bytes(wr_data, per_lo_r);
        CPW_SEL_DUT_LO: dut_lo_nxt = wr_data;
        CPW_SEL_DUT_HI: duty_nxt = join_bytes(wr_data, dut_lo_r);
        CPW_SEL_DEAD: begin
          if (!modulator_block_enable) begin
            dead_nxt = wr_data[DT_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      period_r <= CPW_PERIOD_RST;
      duty_r <= CPW_DUTY_RST;
      per_lo_r <= 8'h00;
      dut_lo_r <= 8'h00;
      dead_r <= CPW_DT_RST;
      unlock_r <= 1'b0;
    end else begin
      period_r <= period_nxt;
      duty_r <= duty_nxt;
      per_lo_r <= per_lo_nxt;
      dut_lo_r <= dut_lo_nxt;
      dead_r <= dead_nxt;
      unlock_r <= unlock_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Period counter and overflow flag
  assign wrap = modulator_block_enable && (cnt_r >= period_r);

  always_comb begin
    cnt_nxt = '0;
    if (modulator_block_enable && !wrap) begin
      cnt_nxt = cnt_r + VAL_W'(1);
    end
    ovf_nxt = ovf_r;
    if (irq_clear) begin
      ovf_nxt = 1'b0;
    end
    if (wrap) begin
      ovf_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output shaping
  assign raw_high = modulator_block_enable && (cnt_r < duty_r);
  assign both = out_a_enable && out_b_enable;
  assign req_a = modulator_block_enable && out_a_enable && raw_high;
  assign req_b = modulator_block_enable && out_b_enable && !raw_high;

  cpw_dead_time #(.DT_W(DT_W)) u_dt_a (
    .sys_clk(sys_clk),
    .reset(reset),
    .req(req_a),
    .other_on(both && on_b),
    .dead(both ? dead_r : '0),
    .on(on_a)
  );

  cpw_dead_time #(.DT_W(DT_W)) u_dt_b (
    .sys_clk(sys_clk),
    .reset(reset),
    .req(req_b),
    .other_on(both && on_a),
    .dead(both ? dead_r : '0),
    .on(on_b)
  );

  always_comb begin
    a_nxt = on_a ^ output_polarity_select;
    b_nxt = on_b ^ output_polarity_select;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      a_r <= 1'b0;
      b_r <= 1'b0;
    end else begin
      a_r <= a_nxt;
      b_r <= b_nxt;
    end
  end

  assign pwm_out_a = a_r;
  assign pwm_out_b = b_r;
  assign ovf_flag = ovf_r;
  assign irq = ovf_r && irq_enable;
  assign unlocked = unlock_r;
  assign period_value = period_r;
  assign duty_value = duty_r;
  assign dead_time = dead_r;

  ////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_lo_write;
    wr_ok && wr_sel == CPW_SEL_PER_LO;
  endsequence

  property p_lo_only;
    @(posedge sys_clk) disable iff (reset)
      s_lo_write |=> $stable(period_r);
  endproperty
  a_lo_only: assert property (p_lo_only) else $error("low byte changed period");

  property p_hi_update;
    @(posedge sys_clk) disable iff (reset)
      (wr_ok && wr_sel == CPW_SEL_PER_HI) |=> period_r == join_bytes($past(wr_data), $past(per_lo_r));
  endproperty
  a_hi_update: assert property (p_hi_update) else $error("period not joined");

  property p_locked;
    @(posedge sys_clk) disable iff (reset)
      (wr_en && !unlock_r && wr_sel != CPW_SEL_UNLOCK) |=> $stable(duty_r) && $stable(dead_r);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took effect");

  property p_dead_guard;
    @(posedge sys_clk) disable iff (reset)
      modulator_block_enable |=> $stable(dead_r);
  endproperty
  a_dead_guard: assert property (p_dead_guard) else $error("dead time changed while enabled");

  property p_ovf_set;
    @(posedge sys_clk) disable iff (reset)
      wrap |=> ovf_r;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow not flagged");

  property p_irq_gate;
    @(posedge sys_clk) disable iff (reset)
      (irq_clear && !wrap) |=> !ovf_flag && !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq not cleared");

  property p_sticky;
    @(posedge sys_clk) disable iff (reset)
      (ovf_r && !irq_clear) |=> ovf_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

  property p_no_overlap;
    @(posedge sys_clk) disable iff (reset)
      both |-> !(on_a && on_b);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both outputs active");

  property p_polarity;
    @(posedge sys_clk) disable iff (reset)
      1'b1 |=> pwm_out_a == ($past(on_a) ^ $past(output_polarity_select));
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity wrong");

  property p_dead_gap;
    @(posedge sys_clk) disable iff (reset)
      (both && dead_r != '0 && $fell(on_b)) |-> !on_a;
  endproperty
  a_dead_gap: assert property (p_dead_gap) else $error("no dead gap");

  property p_disabled_off;
    @(posedge sys_clk) disable iff (reset)
      !out_a_enable |=> !on_a;
  endproperty
  a_disabled_off: assert property (p_disabled_off) else $error("disabled output active");
endmodule
